// ==== rtl/bru_decode.sv ====
// opcode decoder of the bit rotate unit
`timescale 1ns/10ps
module bru_decode (
  input logic [31:0] insn,
  output bru_pkg::bru_op_t op,
  output bru_pkg::bru_src_t src,
  output logic [2:0] sel,
  output logic use_iy,
  output logic [7:0] disp,
  output logic [2:0] len,
  output logic illegal
);
  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;

  function automatic bru_pkg::bru_op_t grp(input logic [4:0] g);
    if (g == bru_pkg::GRP_RLC) return bru_pkg::OP_RLC;
    if (g == bru_pkg::GRP_RL) return bru_pkg::OP_RL;
    if (g == bru_pkg::GRP_RR) return bru_pkg::OP_RR;
    return bru_pkg::OP_NONE;
  endfunction

  assign b0 = insn[7:0];
  assign b1 = insn[15:8];
  assign b2 = insn[23:16];
  assign b3 = insn[31:24];

  always_comb begin
    op = bru_pkg::OP_NONE;
    src = bru_pkg::SRC_REG;
    sel = bru_pkg::SEL_ACC;
    use_iy = 1'b0;
    disp = 8'h00;
    len = bru_pkg::LEN_SHORT;
    if (b0 == bru_pkg::OPC_ACC_RL) begin
      op = bru_pkg::OP_ACC_RL;
    end else if (b0 == bru_pkg::OPC_ACC_RLC) begin
      op = bru_pkg::OP_ACC_RLC;
    end else if (b0 == bru_pkg::OPC_ACC_RR) begin
      op = bru_pkg::OP_ACC_RR;
    end else if (b0 == bru_pkg::PFX_EXT && b1 == bru_pkg::OPC_NIB_L) begin
      op = bru_pkg::OP_NIB_L;
      src = bru_pkg::SRC_PTR;
      len = bru_pkg::LEN_PFX;
    end else if (b0 == bru_pkg::PFX_BIT) begin
      op = grp(b1[7:3]);
      len = bru_pkg::LEN_PFX;
      // code 110 names the pointer operand, never a register
      if (b1[2:0] == bru_pkg::SEL_MEM) begin
        src = bru_pkg::SRC_PTR;
      end else begin
        sel = b1[2:0];
      end
    end else if ((b0 == bru_pkg::PFX_IX || b0 == bru_pkg::PFX_IY) && b1 == bru_pkg::PFX_BIT &&
                 b3[2:0] == bru_pkg::SEL_MEM) begin
      op = grp(b3[7:3]);
      src = bru_pkg::SRC_IDX;
      use_iy = (b0 == bru_pkg::PFX_IY);
      disp = b2;
      len = bru_pkg::LEN_IDX;
    end
    illegal = (op == bru_pkg::OP_NONE);
  end
endmodule

// ==== rtl/bru_pkg.sv ====
// constants, types and shared helpers of the bit rotate unit
package bru_pkg;
  // register map, byte addresses on the register bus
  localparam logic [7:0] REG_INSN = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_GPR_LO = 8'h08;
  localparam logic [7:0] REG_GPR_HI = 8'h0c;
  localparam logic [7:0] REG_INDEX = 8'h10;
  localparam logic [7:0] REG_ADDR = 8'h14;
  localparam logic [7:0] REG_MEM = 8'h40;
  localparam logic [7:0] WIN_MASK = 8'hf0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control write bits and status read fields
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned CTRL_CLR = 1;
  localparam int unsigned STS_BUSY = 0;
  localparam int unsigned STS_DONE = 1;
  localparam int unsigned STS_ILL = 2;
  localparam int unsigned STS_LEN = 4;
  // opcode bytes
  localparam logic [7:0] PFX_BIT = 8'hcb;
  localparam logic [7:0] PFX_IX = 8'hdd;
  localparam logic [7:0] PFX_IY = 8'hfd;
  localparam logic [7:0] PFX_EXT = 8'hed;
  localparam logic [7:0] OPC_NIB_L = 8'h6f;
  localparam logic [7:0] OPC_ACC_RLC = 8'h07;
  localparam logic [7:0] OPC_ACC_RL = 8'h17;
  localparam logic [7:0] OPC_ACC_RR = 8'h1f;
  localparam logic [4:0] GRP_RLC = 5'h00;
  localparam logic [4:0] GRP_RL = 5'h02;
  localparam logic [4:0] GRP_RR = 5'h03;
  localparam logic [2:0] SEL_MEM = 3'h6;
  localparam logic [2:0] SEL_ACC = 3'h7;
  localparam logic [2:0] LEN_SHORT = 3'h1;
  localparam logic [2:0] LEN_PFX = 3'h2;
  localparam logic [2:0] LEN_IDX = 3'h4;
  // flag bit positions
  localparam int unsigned FLG_S = 7;
  localparam int unsigned FLG_Z = 6;
  localparam int unsigned FLG_H = 4;
  localparam int unsigned FLG_PV = 2;
  localparam int unsigned FLG_N = 1;
  localparam int unsigned FLG_C = 0;
  localparam logic [7:0] SZP_MASK = 8'hc4;
  localparam logic [7:0] HN_MASK = 8'h12;
  // storage sizes
  localparam int unsigned NUM_GPR = 8;
  localparam int unsigned MEM_DEPTH = 16;
  localparam int unsigned MEM_AW = 4;

  typedef enum logic [2:0] {
    OP_NONE, OP_RLC, OP_RL, OP_RR, OP_ACC_RLC, OP_ACC_RL, OP_ACC_RR, OP_NIB_L
  } bru_op_t;
  typedef enum logic [1:0] {SRC_REG, SRC_PTR, SRC_IDX} bru_src_t;

  function automatic logic [7:0] szp(input logic [7:0] v);
    logic [7:0] f;
    f = 8'h00;
    f[FLG_S] = v[7];
    f[FLG_Z] = (v == 8'h00);
    f[FLG_PV] = ~^v;
    return f;
  endfunction

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == REG_INSN) || (a == REG_CTRL) || (a == REG_GPR_LO) || (a == REG_GPR_HI) ||
           (a == REG_INDEX) || (a == REG_ADDR) || ((a & WIN_MASK) == REG_MEM);
  endfunction
endpackage

// ==== rtl/bru_rotate.sv ====
// rotate datapath and flag generation
`timescale 1ns/10ps
module bru_rotate (
  input bru_pkg::bru_op_t op,
  input logic [7:0] opnd,
  input logic [7:0] acc,
  input logic [7:0] flags_in,
  output logic [7:0] res,
  output logic [7:0] acc_out,
  output logic [7:0] flags_out
);
  logic c_in;
  logic [7:0] keep;

  assign c_in = flags_in[bru_pkg::FLG_C];
  // short accumulator forms keep sign, zero and parity
  assign keep = flags_in & bru_pkg::SZP_MASK;

  always_comb begin
    res = opnd;
    acc_out = acc;
    flags_out = flags_in;
    unique case (op)
      bru_pkg::OP_RLC: begin
        res = {opnd[6:0], opnd[7]};
        flags_out = bru_pkg::szp(res) | {7'h00, opnd[7]};
      end
      bru_pkg::OP_RL: begin
        res = {opnd[6:0], c_in};
        flags_out = bru_pkg::szp(res) | {7'h00, opnd[7]};
      end
      bru_pkg::OP_RR: begin
        res = {c_in, opnd[7:1]};
        flags_out = bru_pkg::szp(res) | {7'h00, opnd[0]};
      end
      bru_pkg::OP_ACC_RLC: begin
        res = {opnd[6:0], opnd[7]};
        flags_out = keep | {7'h00, opnd[7]};
      end
      bru_pkg::OP_ACC_RL: begin
        res = {opnd[6:0], c_in};
        flags_out = keep | {7'h00, opnd[7]};
      end
      bru_pkg::OP_ACC_RR: begin
        res = {c_in, opnd[7:1]};
        flags_out = keep | {7'h00, opnd[0]};
      end
      bru_pkg::OP_NIB_L: begin
        res = {opnd[3:0], acc[3:0]};
        acc_out = {acc[7:4], opnd[7:4]};
        flags_out = bru_pkg::szp(acc_out) | {7'h00, c_in};
      end
      bru_pkg::OP_NONE: begin
        res = opnd;
      end
    endcase
  end
endmodule

// ==== rtl/bru_top.sv ====
// bit rotate unit: register file, operand memory, engine and register bus slave
`timescale 1ns/10ps
module bru_top (
  input logic aclk,
  input logic aresetn,
  input logic [7:0] awaddr,
  input logic awvalid,
  output logic awready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  input logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input logic bready,
  input logic [7:0] araddr,
  input logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input logic rready
);
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WRITE} bru_state_t;

  bru_state_t st_q;
  logic awready_q, aw_got_q, wready_q, w_got_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rd_word;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] insn_q;
  logic [7:0] gpr_q [bru_pkg::NUM_GPR];
  logic [7:0] mem_q [bru_pkg::MEM_DEPTH];
  logic [15:0] ix_q, iy_q, addr_q, ea, idx_base;
  logic [7:0] opnd_q, acc_cur, flags_cur, alu_res, alu_acc, alu_flags;
  logic done_q, illegal_q;
  logic wr_fire, sw_wr, idle, go_req, clr_req;
  bru_pkg::bru_op_t dec_op;
  bru_pkg::bru_src_t dec_src;
  logic [2:0] dec_sel, dec_len;
  logic dec_iy, dec_illegal;
  logic [7:0] dec_disp;

  bru_decode u_dec (
    .insn(insn_q),
    .op(dec_op),
    .src(dec_src),
    .sel(dec_sel),
    .use_iy(dec_iy),
    .disp(dec_disp),
    .len(dec_len),
    .illegal(dec_illegal)
  );

  bru_rotate u_rot (
    .op(dec_op),
    .opnd(opnd_q),
    .acc(acc_cur),
    .flags_in(flags_cur),
    .res(alu_res),
    .acc_out(alu_acc),
    .flags_out(alu_flags)
  );

  // flags live in the slot of code 110, which no register uses
  assign flags_cur = gpr_q[bru_pkg::SEL_MEM];
  assign acc_cur = gpr_q[bru_pkg::SEL_ACC];
  assign idx_base = dec_iy ? iy_q : ix_q;
  always_comb begin
    ea = {gpr_q[4], gpr_q[5]};
    if (dec_src == bru_pkg::SRC_IDX) begin
      ea = idx_base + {{8{dec_disp[7]}}, dec_disp};
    end
  end

  assign idle = (st_q == ST_IDLE);
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;
  assign sw_wr = wr_fire && bru_pkg::is_mapped(awaddr_q);
  assign go_req = sw_wr && idle && awaddr_q == bru_pkg::REG_CTRL && wstrb_q[0] &&
                  wdata_q[bru_pkg::CTRL_GO];
  assign clr_req = sw_wr && awaddr_q == bru_pkg::REG_CTRL && wstrb_q[0] &&
                   wdata_q[bru_pkg::CTRL_CLR];

  // write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_got_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end else if (!aw_got_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_got_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_got_q <= 1'b1;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end else if (!w_got_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  // write response; writes while busy other than a control clear are dropped but still answered, okay when mapped and slave error when not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= bru_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= bru_pkg::is_mapped(awaddr_q) ? bru_pkg::RESP_OKAY : bru_pkg::RESP_SLVERR;
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if ((araddr & bru_pkg::WIN_MASK) == bru_pkg::REG_MEM) begin
      for (int b = 0; b < 4; b++) begin
        rd_word[8*b +: 8] = mem_q[{araddr[3:2], 2'(b)}];
      end
    end else begin
      unique case (araddr)
        bru_pkg::REG_INSN: rd_word = insn_q;
        bru_pkg::REG_CTRL: begin
          rd_word[bru_pkg::STS_BUSY] = !idle;
          rd_word[bru_pkg::STS_DONE] = done_q;
          rd_word[bru_pkg::STS_ILL] = illegal_q;
          rd_word[bru_pkg::STS_LEN +: 3] = dec_len;
        end
        bru_pkg::REG_GPR_LO: rd_word = {gpr_q[3], gpr_q[2], gpr_q[1], gpr_q[0]};
        bru_pkg::REG_GPR_HI: rd_word = {flags_cur, acc_cur, gpr_q[5], gpr_q[4]};
        bru_pkg::REG_INDEX: rd_word = {iy_q, ix_q};
        bru_pkg::REG_ADDR: rd_word = {16'h0000, addr_q};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  // read channels: one read in flight, data one edge after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= bru_pkg::RESP_OKAY;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= bru_pkg::is_mapped(araddr) ? bru_pkg::RESP_OKAY : bru_pkg::RESP_SLVERR;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  // instruction bytes, lowest byte first; frozen while busy so decode stays stable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      insn_q <= 32'h0000_0000;
    end else if (sw_wr && idle && awaddr_q == bru_pkg::REG_INSN) begin
      insn_q <= bru_pkg::merge32(insn_q, wdata_q, wstrb_q);
    end
  end

  // register file, index registers and operand memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < bru_pkg::NUM_GPR; i++) begin
        gpr_q[i] <= 8'h00;
      end
      for (int i = 0; i < bru_pkg::MEM_DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
      ix_q <= 16'h0000;
      iy_q <= 16'h0000;
    end else if (st_q == ST_WRITE) begin
      gpr_q[bru_pkg::SEL_MEM] <= alu_flags;
      if (dec_op == bru_pkg::OP_NIB_L) begin
        gpr_q[bru_pkg::SEL_ACC] <= alu_acc;
        mem_q[addr_q[bru_pkg::MEM_AW-1:0]] <= alu_res;
      end else if (dec_src == bru_pkg::SRC_REG) begin
        gpr_q[dec_sel] <= alu_res;
      end else begin
        mem_q[addr_q[bru_pkg::MEM_AW-1:0]] <= alu_res;
      end
    end else if (sw_wr && idle) begin
      if ((awaddr_q & bru_pkg::WIN_MASK) == bru_pkg::REG_MEM) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_q[b]) begin
            mem_q[{awaddr_q[3:2], 2'(b)}] <= wdata_q[8*b +: 8];
          end
        end
      end else if (awaddr_q == bru_pkg::REG_INDEX) begin
        {iy_q, ix_q} <= bru_pkg::merge32({iy_q, ix_q}, wdata_q, wstrb_q);
      end else if (awaddr_q == bru_pkg::REG_GPR_LO || awaddr_q == bru_pkg::REG_GPR_HI) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_q[b] && awaddr_q == bru_pkg::REG_GPR_LO) begin
            gpr_q[b] <= wdata_q[8*b +: 8];
          end else if (wstrb_q[b]) begin
            // high word lanes: H, L, A, flags; A sits in slot 7, flags in slot 6
            gpr_q[(b < 2) ? 4 + b : 9 - b] <= wdata_q[8*b +: 8];
          end
        end
      end
    end
  end

  // engine: fetch operand, then rotate and write back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      addr_q <= 16'h0000;
      opnd_q <= 8'h00;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (go_req && !dec_illegal) begin
            st_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          addr_q <= ea;
          // memory window is small: only the low address bits select a byte
          opnd_q <= (dec_src == bru_pkg::SRC_REG) ? gpr_q[dec_sel] :
                    mem_q[ea[bru_pkg::MEM_AW-1:0]];
          st_q <= ST_WRITE;
        end
        ST_WRITE: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // status: a completing operation beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      if (st_q == ST_WRITE || (go_req && dec_illegal)) begin
        done_q <= 1'b1;
      end else if (clr_req) begin
        done_q <= 1'b0;
      end
      if (go_req && dec_illegal) begin
        illegal_q <= 1'b1;
      end else if (clr_req || go_req) begin
        illegal_q <= 1'b0;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // checks
  logic wr_rl, wr_gen, wr_acc, wr_nib, c_now;
  logic [7:0] mem_at;
  logic [15:0] idx_exp;
  assign wr_rl = st_q == ST_WRITE && dec_op == bru_pkg::OP_RL;
  assign wr_gen = st_q == ST_WRITE && (dec_op == bru_pkg::OP_RL || dec_op == bru_pkg::OP_RLC ||
                  dec_op == bru_pkg::OP_RR);
  assign wr_acc = st_q == ST_WRITE && (dec_op == bru_pkg::OP_ACC_RL ||
                  dec_op == bru_pkg::OP_ACC_RLC || dec_op == bru_pkg::OP_ACC_RR);
  assign wr_nib = st_q == ST_WRITE && dec_op == bru_pkg::OP_NIB_L;
  assign c_now = flags_cur[bru_pkg::FLG_C];
  assign mem_at = mem_q[addr_q[bru_pkg::MEM_AW-1:0]];
  assign idx_exp = idx_base + {{8{dec_disp[7]}}, dec_disp};

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rl_carry;
    wr_rl && dec_src == bru_pkg::SRC_REG |=> c_now == $past(opnd_q[7]) &&
      gpr_q[$past(dec_sel)] == {$past(opnd_q[6:0]), $past(c_now)};
  endproperty
  a_rl_carry: assert property (p_rl_carry) else $error("left rotate through carry wrong");

  property p_idx_addr;
    st_q == ST_FETCH && dec_src == bru_pkg::SRC_IDX |=> addr_q == $past(idx_exp) ##1 1'b1;
  endproperty
  a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");

  property p_no_reg6;
    dec_src == bru_pkg::SRC_REG |-> dec_sel != bru_pkg::SEL_MEM;
  endproperty
  a_no_reg6: assert property (p_no_reg6) else $error("code 110 used as register");

  property p_len;
    // length judged from the first byte alone, not from the decoder's outputs
    !dec_illegal |-> dec_len ==
      ((insn_q[7:0] == bru_pkg::PFX_IX || insn_q[7:0] == bru_pkg::PFX_IY) ? bru_pkg::LEN_IDX :
      ((insn_q[7:0] == bru_pkg::PFX_BIT || insn_q[7:0] == bru_pkg::PFX_EXT) ? bru_pkg::LEN_PFX :
      bru_pkg::LEN_SHORT));
  endproperty
  a_len: assert property (p_len) else $error("instruction length wrong");

  property p_gen_flags;
    wr_gen |=> (flags_cur & bru_pkg::SZP_MASK) == bru_pkg::szp($past(alu_res)) &&
      (flags_cur & bru_pkg::HN_MASK) == 8'h00;
  endproperty
  a_gen_flags: assert property (p_gen_flags) else $error("rotate flags wrong");

  property p_acc_keep;
    wr_acc |=> (flags_cur & bru_pkg::SZP_MASK) == ($past(flags_cur) & bru_pkg::SZP_MASK) &&
      (flags_cur & bru_pkg::HN_MASK) == 8'h00;
  endproperty
  a_acc_keep: assert property (p_acc_keep) else $error("short form touched S Z P");

  property p_nib;
    wr_nib |=> mem_at == {$past(opnd_q[3:0]), $past(acc_cur[3:0])} &&
      acc_cur == {$past(acc_cur[7:4]), $past(opnd_q[7:4])};
  endproperty
  a_nib: assert property (p_nib) else $error("nibble rotate data wrong");

  property p_nib_flags;
    wr_nib |=> c_now == $past(c_now) &&
      (flags_cur & bru_pkg::SZP_MASK) == bru_pkg::szp(acc_cur);
  endproperty
  a_nib_flags: assert property (p_nib_flags) else $error("nibble rotate flags wrong");

  property p_go_seq;
    go_req && !dec_illegal |=> st_q == ST_FETCH ##1 st_q == ST_WRITE ##1 idle && done_q;
  endproperty
  a_go_seq: assert property (p_go_seq) else $error("engine sequence wrong");

  property p_bhold;
    bvalid_q && !bready |=> bvalid_q && $stable(bresp_q);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

  c_nib: cover property (wr_nib);
  c_idx: cover property (st_q == ST_FETCH && dec_src == bru_pkg::SRC_IDX);
  c_ill: cover property (go_req && dec_illegal);
  c_rr_ptr: cover property (st_q == ST_WRITE && dec_op == bru_pkg::OP_RR &&
                            dec_src == bru_pkg::SRC_PTR);
endmodule

// ==== sim/bru_host.sv ====
// register bus master standing on the far side of the rotate unit
`timescale 1ns/10ps
module bru_host (
  input logic aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input logic wready,
  input logic [1:0] bresp,
  input logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input logic arready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic rvalid,
  output logic rready
);
  int timeouts = 0;
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // bounded waits: a stuck slave counts as a timeout, never a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    r = 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      timeouts++;
      tb_top.final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    d = 'x;
    r = 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      timeouts++;
      tb_top.final_report();
    end
  endtask
endmodule

// ==== sim/tb_top.sv ====
// self-checking bench of the bit rotate unit
`timescale 1ns/10ps
module tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int error_cnt = 0;
  int tests_run = 0;
  bru_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready);
  bru_host host_u (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic final_report();
    error_cnt += host_u.timeouts;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t data got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t resp got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host_u.wr(a, d, r);
    chk_resp(r, bru_pkg::RESP_OKAY);
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    host_u.rd(a, d, r);
    chk(d, exp);
    chk_resp(r, bru_pkg::RESP_OKAY);
  endtask
  // loads the state, starts the engine, polls done with a bounded count
  task automatic exec(input logic [31:0] insn, lo, hi, idx, input logic [7:0] ma,
                      input logic [31:0] mw, input logic [31:0] exp_st);
    logic [31:0] st;
    logic [1:0] r;
    wr(bru_pkg::REG_CTRL, 32'h0000_0002);
    wr(bru_pkg::REG_INSN, insn);
    wr(bru_pkg::REG_GPR_LO, lo);
    wr(bru_pkg::REG_GPR_HI, hi);
    wr(bru_pkg::REG_INDEX, idx);
    wr(ma, mw);
    wr(bru_pkg::REG_CTRL, 32'h0000_0001);
    for (int n = 0; n < 20; n++) begin
      host_u.rd(bru_pkg::REG_CTRL, st, r);
      if (st[bru_pkg::STS_DONE] === 1'b1) break;
    end
    chk(st, exp_st);
    // a start that never completes ends the run here
    if (st[bru_pkg::STS_DONE] !== 1'b1) final_report();
  endtask
  task automatic t_reset();
    expect_reg(bru_pkg::REG_GPR_LO, 32'h0);
    // empty instruction word decodes as a one-byte illegal form
    expect_reg(bru_pkg::REG_CTRL, 32'h10);
  endtask
  task automatic t_rl_reg();
    exec(32'h0000_10cb, 32'h0000_0080, 32'h0100_0000, 0, 8'h40, 0, 32'h22);
    expect_reg(bru_pkg::REG_GPR_LO, 32'h0000_0001);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h0100_0000);
  endtask
  task automatic t_rlc_acc();
    exec(32'h0000_07cb, 0, 32'h0081_0000, 0, 8'h40, 0, 32'h22);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h0503_0000);
  endtask
  task automatic t_rr_reg();
    exec(32'h0000_1bcb, 32'h0100_0000, 0, 0, 8'h40, 0, 32'h22);
    expect_reg(bru_pkg::REG_GPR_LO, 32'h0);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h4500_0000);
  endtask
  // short forms keep sign, zero and parity even when they disagree with the result
  task automatic t_short();
    exec(32'h17, 0, 32'hd680_0000, 0, 8'h40, 0, 32'h12);
    expect_reg(bru_pkg::REG_GPR_HI, 32'hc500_0000);
    exec(32'h07, 0, 32'h0081_0000, 0, 8'h40, 0, 32'h12);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h0103_0000);
    exec(32'h1f, 0, 32'h0101_0000, 0, 8'h40, 0, 32'h12);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h0180_0000);
  endtask
  task automatic t_ptr();
    exec(32'h0000_16cb, 0, 32'h0000_0500, 0, 8'h44, 32'h0000_4000, 32'h22);
    expect_reg(8'h44, 32'h0000_8000);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h8000_0500);
    expect_reg(bru_pkg::REG_ADDR, 32'h5);
    exec(32'h0000_1ecb, 0, 32'h0000_0500, 0, 8'h44, 32'h0000_0300, 32'h22);
    expect_reg(8'h44, 32'h0000_0100);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h0100_0500);
  endtask
  task automatic t_idx();
    exec(32'h1eff_cbfd, 0, 32'h0100_0000, 32'h0008_0000, 8'h44, 32'h0200_0000, 32'h42);
    expect_reg(8'h44, 32'h8100_0000);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h8400_0000);
    expect_reg(bru_pkg::REG_ADDR, 32'h7);
    exec(32'h0602_cbdd, 0, 0, 32'h0000_0001, 8'h40, 32'h8000_0000, 32'h42);
    expect_reg(8'h40, 32'h0100_0000);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h0100_0000);
  endtask
  task automatic t_nib();
    exec(32'h0000_6fed, 0, 32'h0134_0300, 0, 8'h40, 32'h1200_0000, 32'h22);
    expect_reg(8'h40, 32'h2400_0000);
    expect_reg(bru_pkg::REG_GPR_HI, 32'h0131_0300);
  endtask
  task automatic t_bad();
    logic [31:0] d;
    logic [1:0] r;
    exec(32'h0100_cbdd, 0, 0, 0, 8'h40, 0, 32'h16);
    host_u.rd(8'h20, d, r);
    chk(d, 32'h0);
    chk_resp(r, bru_pkg::RESP_SLVERR);
    host_u.wr(8'h20, 32'hffff_ffff, r);
    chk_resp(r, bru_pkg::RESP_SLVERR);
  endtask
  initial begin
    repeat (50000) @(posedge aclk);
    error_cnt++;
    final_report();
  end
  initial begin
    aresetn = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_rl_reg();
    t_rlc_acc();
    t_rr_reg();
    t_short();
    t_ptr();
    t_idx();
    t_nib();
    t_bad();
    final_report();
  end
endmodule
